// ===== rtl/fupc_map.svh
/*
 * register offsets, key and mode codes, reset values and timing figures
 * of the flash user-program controller.
 * assumes: included by bare name from rtl files; definitions only.
 */
`ifndef FUPC_MAP_SVH
`define FUPC_MAP_SVH

// register byte offsets on the bus
`define FUPC_OFF_KEY      8'h00
`define FUPC_OFF_MODE     8'h04
`define FUPC_OFF_SECT_HI  8'h08
`define FUPC_OFF_SECT_LO  8'h0c
`define FUPC_OFF_STATUS   8'h10

// key and mode codes
`define FUPC_UNLOCK_KEY   8'ha5
`define FUPC_KEY_RST      8'h00
`define FUPC_MODE_RST     8'h00
`define FUPC_SECT_RST     8'h00
`define FUPC_PROG_CODE    7'h28
`define FUPC_ERASE_CODE   8'ha1
`define FUPC_LOCK_CODE    4'h6
`define FUPC_START_BIT    0
`define FUPC_LOCK_LSB     4
`define FUPC_SECT_LO_BIT  7

// status register fields
`define FUPC_ST_LOCKED    0
`define FUPC_ST_BUSY      1
`define FUPC_ST_UNLOCKED  2

// flash geometry
`define FUPC_ADDR_W       13
`define FUPC_SECT_W       7
`define FUPC_ERASED_BYTE  8'hff

// timing: least erase time and clock rate
`define FUPC_ERASE_MIN_US 4000
`define FUPC_CLK_MHZ      200
`define FUPC_ERASE_CYC    (`FUPC_ERASE_MIN_US * `FUPC_CLK_MHZ)

`endif

// ===== rtl/fupc_pkg.sv
/*
 * types shared by the flash user-program controller and its array.
 * assumes: compiled before every other rtl file.
 */
package fupc_pkg;

	// command from the controller to the flash array
	typedef enum logic [2:0]
	{
		FUPC_CMD_NONE,
		FUPC_CMD_PROG,
		FUPC_CMD_ERASE_SECT,
		FUPC_CMD_ERASE_CHIP,
		FUPC_CMD_SET_LOCK
	} fupc_cmd_t;

	typedef enum logic [1:0]
	{
		FUPC_ARR_IDLE,
		FUPC_ARR_ERASE_SECT,
		FUPC_ARR_ERASE_CHIP
	} fupc_arr_state_t;

endpackage

// ===== rtl/fupc_flash_if.sv
/*
 * carrier between the controller and the flash array.
 * assumes: both ends on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface fupc_flash_if;
	import fupc_pkg::*;
	fupc_cmd_t   cmd;     // one-cycle command
	logic [15:0] addr;    // program or erase address
	logic [7:0]  wdata;   // program data
	logic        rd;      // read strobe
	logic [15:0] raddr;   // read address
	logic [7:0]  rdata;   // read data, one cycle after rd
	logic        busy;    // erase in progress
	logic        locked;  // hard lock state

	modport ctrl (output cmd, addr, wdata, rd, raddr, input rdata, busy, locked);
	modport mem  (input cmd, addr, wdata, rd, raddr, output rdata, busy, locked);
endinterface

`default_nettype wire

// ===== rtl/fupc_flash_array.sv
/*
 * flash byte array with and-style byte programming, sector and chip erase
 * and a hard lock bit that survives the system reset.
 * assumes: commands only from the controller; chip erase from tool mode.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fupc_map.svh"

module fupc_flash_array
	import fupc_pkg::*;
#(
	parameter int ADDR_W = `FUPC_ADDR_W
)
(
	input  wire logic   clk_i,
	input  wire logic   rst_b_i,     // system reset, keeps lock
	input  wire logic   nv_init_b_i, // clears the lock bit only
	fupc_flash_if.mem   fl
);
	localparam int SECT_W = `FUPC_SECT_W;

	typedef struct packed
	{
		fupc_arr_state_t   st;
		logic [ADDR_W-1:0] ptr;
		logic [ADDR_W-1:0] last;
		logic [7:0]        rdata;
		logic              locked;
	} fupc_arr_t;

	fupc_arr_t s_ff;
	fupc_arr_t nxt_s;
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	logic       wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;

	// parameter check at elaboration
	if (ADDR_W < 8 || ADDR_W > 15)
		$error("fupc_flash_array: ADDR_W out of range");

	// command decode and erase walk
	always_comb
	begin
		nxt_s   = s_ff;
		wr_en   = 1'b0;
		wr_addr = fl.addr[ADDR_W-1:0];
		wr_data = fl.wdata & mem[fl.addr[ADDR_W-1:0]]; // bits only clear
		case (s_ff.st)
			FUPC_ARR_IDLE:
			begin
				case (fl.cmd)
					FUPC_CMD_PROG:       wr_en = ~s_ff.locked;
					FUPC_CMD_SET_LOCK:   nxt_s.locked = 1'b1;
					FUPC_CMD_ERASE_SECT:
					begin
						nxt_s.st   = FUPC_ARR_ERASE_SECT;
						nxt_s.ptr  = {fl.addr[ADDR_W-1:SECT_W], {SECT_W{1'b0}}};
						nxt_s.last = {fl.addr[ADDR_W-1:SECT_W], {SECT_W{1'b1}}};
					end
					FUPC_CMD_ERASE_CHIP:
					begin
						nxt_s.st   = FUPC_ARR_ERASE_CHIP;
						nxt_s.ptr  = '0;
						nxt_s.last = '1;
					end
					default: ;
				endcase
			end
			FUPC_ARR_ERASE_SECT, FUPC_ARR_ERASE_CHIP:
			begin
				wr_en   = 1'b1;
				wr_addr = s_ff.ptr;
				wr_data = `FUPC_ERASED_BYTE;
				nxt_s.ptr = s_ff.ptr + 1'b1;
				if (s_ff.ptr == s_ff.last)
				begin
					nxt_s.st = FUPC_ARR_IDLE;
					if (s_ff.st == FUPC_ARR_ERASE_CHIP)
						nxt_s.locked = 1'b0; // of the two erases only chip erase lifts lock
				end
			end
			default: nxt_s.st = FUPC_ARR_IDLE;
		endcase
		if (fl.rd)
			nxt_s.rdata = mem[fl.raddr[ADDR_W-1:0]]; // byte read
	end

	// state register; lock bit kept across system reset
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			s_ff        <= '0;
			s_ff.locked <= nv_init_b_i ? s_ff.locked : 1'b0;
		end
		else if (!nv_init_b_i)
		begin
			s_ff        <= nxt_s;
			s_ff.locked <= 1'b0;
		end
		else
			s_ff <= nxt_s;
	end

	// non-volatile cells, no reset
	always_ff @(posedge clk_i)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	assign fl.rdata  = s_ff.rdata;
	assign fl.busy   = (s_ff.st != FUPC_ARR_IDLE);
	assign fl.locked = s_ff.locked;

endmodule

`default_nettype wire

// ===== rtl/fupc_top.sv
/*
 * flash user-program controller: unlock key, mode control and sector
 * address registers on ahb-lite, cpu program-memory load/store port,
 * erase stall and hard lock.
 * assumes: one ahb-lite master, single word transfers; cpu port on the
 * same clock; tool chip erase pin asynchronous.
 */
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fupc_map.svh"

module fupc_top
	import fupc_pkg::*;
#(
	parameter int ERASE_CYCLES = `FUPC_ERASE_CYC,
	parameter int ADDR_W       = `FUPC_ADDR_W
)
(
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_B_I,
	input  wire logic        NV_INIT_B_I,
	input  wire logic        TOOL_CHIP_ERASE_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	output logic [31:0]      HRDATA_O,
	input  wire logic        PM_WR_I,
	input  wire logic        PM_RD_I,
	input  wire logic [7:0]  PM_ADDR_HI_I,
	input  wire logic [7:0]  PM_ADDR_LO_I,
	input  wire logic [7:0]  PM_WDATA_I,
	output logic [7:0]       PM_RDATA_O,
	output logic             PM_RVALID_O,
	output logic             CPU_STALL_O
);
	localparam int CNT_W = $clog2(ERASE_CYCLES + 1);

	typedef struct packed
	{
		logic [7:0]       key;
		logic [7:0]       mode;
		logic [7:0]       sect_hi;
		logic             sect_lo7;
		logic             ph_wr;
		logic             ph_rd;
		logic [7:0]       ph_addr;
		logic [31:0]      hrdata;
		logic             erasing;
		logic [CNT_W-1:0] cnt;
		logic             rvalid;
		logic [2:0]       tool_sync;
		logic             tool_lvl;
	} fupc_top_t;

	fupc_top_t s_ff;
	fupc_top_t nxt_s;
	fupc_flash_if fl();

	// parameter checks at elaboration
	if (ERASE_CYCLES < 1)
		$error("fupc_top: ERASE_CYCLES must be at least 1");
	if (ADDR_W < 8 || ADDR_W > 15)
		$error("fupc_top: ADDR_W out of range");

	// register read mux
	function automatic logic [31:0] rd_mux(input fupc_top_t s, input logic [7:0] a,
		input logic lk, input logic bsy);
		logic [31:0] r;
		r = '0;
		case (a)
			`FUPC_OFF_KEY:     r[7:0] = s.key;
			`FUPC_OFF_MODE:    r[7:0] = s.mode;
			`FUPC_OFF_SECT_HI: r[7:0] = s.sect_hi;
			`FUPC_OFF_SECT_LO: r[`FUPC_SECT_LO_BIT] = s.sect_lo7;
			`FUPC_OFF_STATUS:
			begin
				r[`FUPC_ST_LOCKED]   = lk;
				r[`FUPC_ST_BUSY]     = bsy;
				r[`FUPC_ST_UNLOCKED] = (s.key == `FUPC_UNLOCK_KEY);
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	logic        key_ok;
	logic        prog_mode;
	logic [15:0] pm_addr;
	logic        in_sect;
	logic        in_range;

	// key check and store address qualification
	assign key_ok    = (s_ff.key == `FUPC_UNLOCK_KEY);
	assign prog_mode = (s_ff.mode[7:1] == `FUPC_PROG_CODE);
	assign pm_addr   = {PM_ADDR_HI_I, PM_ADDR_LO_I};
	assign in_sect   = (pm_addr[15:`FUPC_SECT_W] == {s_ff.sect_hi, s_ff.sect_lo7});
	assign in_range  = ({1'b0, pm_addr} < 17'(1 << ADDR_W));

	// next-state logic
	always_comb
	begin
		nxt_s       = s_ff;
		fl.cmd      = FUPC_CMD_NONE;
		fl.addr     = {s_ff.sect_hi, s_ff.sect_lo7, {`FUPC_SECT_W{1'b0}}};
		fl.wdata    = PM_WDATA_I;
		fl.rd       = PM_RD_I;
		fl.raddr    = pm_addr;
		nxt_s.rvalid = PM_RD_I;

		// tool chip erase pin: three flops, level taken when 2nd and 3rd agree
		nxt_s.tool_sync = {s_ff.tool_sync[1:0], TOOL_CHIP_ERASE_I};
		if (s_ff.tool_sync[1] == s_ff.tool_sync[2])
			nxt_s.tool_lvl = s_ff.tool_sync[2];

		// ahb address phase capture and read data
		nxt_s.ph_wr = 1'b0;
		nxt_s.ph_rd = 1'b0;
		if (HSEL_I && HREADY_I && HTRANS_I[1])
		begin
			nxt_s.ph_wr   = HWRITE_I;
			nxt_s.ph_rd   = ~HWRITE_I;
			nxt_s.ph_addr = HADDR_I[7:0];
			if (!HWRITE_I)
				nxt_s.hrdata = rd_mux(s_ff, HADDR_I[7:0], fl.locked, s_ff.erasing);
		end

		// ahb data phase write
		if (s_ff.ph_wr)
		begin
			case (s_ff.ph_addr)
				`FUPC_OFF_KEY:     nxt_s.key = HWDATA_I[7:0];
				`FUPC_OFF_SECT_HI: nxt_s.sect_hi = HWDATA_I[7:0];
				`FUPC_OFF_SECT_LO: nxt_s.sect_lo7 = HWDATA_I[`FUPC_SECT_LO_BIT];
				`FUPC_OFF_MODE:
				begin
					if (!s_ff.erasing)
					begin
						nxt_s.mode = HWDATA_I[7:0];
						if (HWDATA_I[7:0] == `FUPC_ERASE_CODE && key_ok && !fl.locked)
						begin
							nxt_s.erasing = 1'b1;
							nxt_s.cnt     = CNT_W'(ERASE_CYCLES - 1);
							fl.cmd        = FUPC_CMD_ERASE_SECT;
						end
						else if (HWDATA_I[7:`FUPC_LOCK_LSB] == `FUPC_LOCK_CODE
							&& HWDATA_I[`FUPC_START_BIT] && key_ok)
						begin
							fl.cmd = FUPC_CMD_SET_LOCK;
							nxt_s.mode[`FUPC_START_BIT] = 1'b0;
						end
					end
				end
				default: ;
			endcase
		end

		// erase timer; start bit cleared when done
		if (s_ff.erasing)
		begin
			if (s_ff.cnt != '0)
				nxt_s.cnt = s_ff.cnt - 1'b1;
			else if (!fl.busy)
			begin
				nxt_s.erasing = 1'b0;
				nxt_s.mode[`FUPC_START_BIT] = 1'b0;
			end
		end

		// byte program on store, only when unlocked and not hard locked
		if (PM_WR_I && key_ok && prog_mode && !fl.locked && !fl.busy
			&& in_sect && in_range && fl.cmd == FUPC_CMD_NONE)
		begin
			fl.cmd  = FUPC_CMD_PROG;
			fl.addr = pm_addr;
		end

		// tool mode chip erase wins over everything except an erase in progress
		if (nxt_s.tool_lvl && !s_ff.tool_lvl && !fl.busy)
			fl.cmd = FUPC_CMD_ERASE_CHIP;
	end

	// state register
	always_ff @(posedge CORE_CLK_I)
	begin
		if (!RST_B_I)
		begin
			s_ff      <= '0;
			s_ff.key  <= `FUPC_KEY_RST;
			s_ff.mode <= `FUPC_MODE_RST;
			s_ff.sect_hi <= `FUPC_SECT_RST;
		end
		else
			s_ff <= nxt_s;
	end

	fupc_flash_array #(.ADDR_W(ADDR_W)) u_array
	(
		.clk_i       (CORE_CLK_I),
		.rst_b_i     (RST_B_I),
		.nv_init_b_i (NV_INIT_B_I),
		.fl          (fl.mem)
	);

	// outputs
	assign HREADYOUT_O = 1'b1;                                         // zero wait
	assign HRESP_O     = 1'b0;                                         // always okay
	assign HRDATA_O    = s_ff.hrdata;
	assign PM_RDATA_O  = fl.rdata;
	assign PM_RVALID_O = s_ff.rvalid;
	assign CPU_STALL_O = s_ff.erasing;

endmodule

`default_nettype wire

// ===== dv/fupc_checker.sv
/* port assertions for the flash user-program controller.
 * assumes: bound into fupc_top; one clock, reset sync active low. */
`timescale 1ns/1ps
`default_nettype none
module fupc_checker
#(
	parameter int ERASE_CYCLES = 200
)
(
	input wire logic		CORE_CLK_I,
	input wire logic		RST_B_I,
	input wire logic		HSEL_I,
	input wire logic [31:0]	HADDR_I,
	input wire logic [1:0]	HTRANS_I,
	input wire logic		HWRITE_I,
	input wire logic [31:0]	HWDATA_I,
	input wire logic		HREADY_I,
	input wire logic		HREADYOUT_O,
	input wire logic		HRESP_O,
	input wire logic [31:0]	HRDATA_O,
	input wire logic		PM_RD_I,
	input wire logic		PM_RVALID_O,
	input wire logic		CPU_STALL_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);
	logic	take;
	logic	mode_wr_ff;
	logic	lo_rd_ff;
	int		stall_cnt_ff;
	// address phase accepted at this edge
	assign take = HSEL_I && HREADY_I && HTRANS_I[1];
	// data phase tracking and stall length count
	always_ff @(posedge CORE_CLK_I)
	begin
		mode_wr_ff <= take && HWRITE_I && (HADDR_I[7:0] == 8'h04);
		lo_rd_ff <= take && !HWRITE_I && (HADDR_I[7:0] == 8'h0c);
		stall_cnt_ff <= CPU_STALL_O ? stall_cnt_ff + 1 : 0;
	end
	sequence s_load;
		PM_RD_I ##1 PM_RVALID_O;
	endsequence
	property p_bus_ok;
		HREADYOUT_O && !HRESP_O;
	endproperty
	property p_rd_answer;
		PM_RD_I |-> s_load;
	endproperty
	property p_rd_quiet;
		!PM_RD_I |=> !PM_RVALID_O;
	endproperty
	property p_rst_quiet;
		$rose(RST_B_I) |-> !CPU_STALL_O && !PM_RVALID_O && (HRDATA_O == 32'h0);
	endproperty
	property p_erase_cause;
		$rose(CPU_STALL_O) |-> $past(mode_wr_ff && (HWDATA_I[7:0] == 8'ha1));
	endproperty
	property p_erase_len;
		$fell(CPU_STALL_O) |-> stall_cnt_ff == ERASE_CYCLES;
	endproperty
	property p_upper_zero;
		HRDATA_O[31:8] == 24'h0;
	endproperty
	property p_sect_lo;
		lo_rd_ff |-> HRDATA_O[6:0] == 7'h0;
	endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus response not ready/okay");
	a_rd_answer: assert property (p_rd_answer) else $error("load not answered");
	a_rd_quiet: assert property (p_rd_quiet) else $error("stray load valid");
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not reset");
	a_erase_cause: assert property (p_erase_cause) else $error("stall w/o erase");
	a_erase_len: assert property (p_erase_len) else $error("bad stall length");
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	a_sect_lo: assert property (p_sect_lo) else $error("sector low bits read");
endmodule
bind fupc_top fupc_checker #(.ERASE_CYCLES(ERASE_CYCLES)) i_chk (.CORE_CLK_I(CORE_CLK_I),
	.RST_B_I(RST_B_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
	.HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O),
	.PM_RD_I(PM_RD_I), .PM_RVALID_O(PM_RVALID_O), .CPU_STALL_O(CPU_STALL_O));
`default_nettype wire

// ===== dv/fupc_cpu_model.sv
/* cpu side model: program-memory stores and loads.
 * assumes: same clock as the controller; tasks called just after an edge. */
`timescale 1ns/1ps
`default_nettype none
module fupc_cpu_model
(
	input wire logic		clk_i,
	input wire logic		stall_i,
	input wire logic [7:0]	rdata_i,
	input wire logic		rvalid_i,
	output logic			wr_o,
	output logic			rd_o,
	output logic [7:0]		hi_o,
	output logic [7:0]		lo_o,
	output logic [7:0]		wdata_o
);
	// idle port at time zero
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		{hi_o, lo_o} = 16'h0;
		wdata_o = 8'h0;
	end
	// the cpu issues nothing while an erase holds it
	task automatic go();
		@(negedge clk_i);
		while (stall_i !== 1'b0) @(negedge clk_i);
		@(posedge clk_i);
	endtask
	// single byte store; lines flip after release
	task automatic store(input logic [15:0] a, input logic [7:0] d);
		go();
		wr_o <= 1'b1;
		{hi_o, lo_o} <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		{hi_o, lo_o} <= ~a;
		wdata_o <= ~d;
	endtask
	// single byte load, answer awaited a bounded time
	task automatic load(input logic [15:0] a, output logic [7:0] d);
		int n;
		go();
		rd_o <= 1'b1;
		{hi_o, lo_o} <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		{hi_o, lo_o} <= ~a;
		n = 0;
		// answer taken at the rising edge where valid is seen high
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (rvalid_i !== 1'b1 && n < 4);
		d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
	endtask
endmodule
`default_nettype wire

// ===== dv/fupc_tb_top.sv
/* self-checking bench for the flash user-program controller.
 * assumes: bus and cpu port on one 200 MHz clock; short erase count. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module fupc_tb_top;
	logic			clk;
	logic			rst_b;
	logic			nv_b;
	logic			chip;
	logic			hsel;
	logic [31:0]	haddr;
	logic [1:0]		htrans;
	logic			hwrite;
	logic [31:0]	hwdata;
	logic			hrdyo;
	logic [31:0]	hrdata;
	logic			wr, rd, rvalid, stall;
	logic [7:0]		hi, lo, wdata, rdata;
	int				err_count = 0;
	int				n_tests = 0;
	int				cyc = 0;
	// erase count above the 128-cycle array walk so the stall length is exact
	fupc_top #(.ERASE_CYCLES(200)) i_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b),
		.NV_INIT_B_I(nv_b), .TOOL_CHIP_ERASE_I(chip), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hrdyo), .HREADYOUT_O(hrdyo), .HRESP_O(), .HRDATA_O(hrdata),
		.PM_WR_I(wr), .PM_RD_I(rd), .PM_ADDR_HI_I(hi), .PM_ADDR_LO_I(lo),
		.PM_WDATA_I(wdata), .PM_RDATA_O(rdata), .PM_RVALID_O(rvalid), .CPU_STALL_O(stall));
	fupc_cpu_model i_cpu (.clk_i(clk), .stall_i(stall), .rdata_i(rdata), .rvalid_i(rvalid),
		.wr_o(wr), .rd_o(rd), .hi_o(hi), .lo_o(lo), .wdata_o(wdata));
	// 5 ns clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// verdict and end of run
	task automatic stop_test();
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			stop_test();
		end
	end
	// one ahb-lite single transfer, waits on ready each phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hrdyo !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hrdyo !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 8'h0, r);
		`CHECK(r, {24'h0, e})
	endtask
	task automatic ld(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] b;
		i_cpu.load(a, b);
		`CHECK(b, e)
	endtask
	task automatic stall_is(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHECK(stall, e)
		@(posedge clk);
	endtask
	task automatic tool_erase();
		chip <= 1'b1;
		repeat (8250) @(posedge clk);
		chip <= 1'b0;
		@(posedge clk);
	endtask
	// main sequence
	initial
	begin
		{rst_b, nv_b, chip, hsel, hwrite} = 5'h0;
		{htrans, haddr, hwdata} = 66'h0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		nv_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++) rd_reg(8'(i * 4), 8'h00);
		wr_reg(8'h20, 8'h5a);
		rd_reg(8'h20, 8'h00);
		tool_erase();
		ld(16'h0310, 8'hff);
		wr_reg(8'h08, 8'h03);
		wr_reg(8'h0c, 8'h7f);
		wr_reg(8'h04, 8'h51);
		rd_reg(8'h0c, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			wr_reg(8'h00, (k != 0) ? 8'ha4 : 8'h00);
			i_cpu.store(16'h0310, 8'h00);
			ld(16'h0310, 8'hff);
		end
		wr_reg(8'h00, 8'ha5);
		for (int i = 0; i < 2; i++)
		begin
			wr_reg(8'h04, 8'h51 ^ 8'(i));
			i_cpu.store(16'h0310 + 16'(i), 8'haa ^ 8'(i));
			ld(16'h0310 + 16'(i), 8'haa ^ 8'(i));
		end
		i_cpu.store(16'h037f, 8'h3c);
		ld(16'h037f, 8'h3c);
		i_cpu.store(16'h0380, 8'h00);
		ld(16'h0380, 8'hff);
		rd_reg(8'h10, 8'h04);
		wr_reg(8'h04, 8'ha1);
		stall_is(1'b1);
		rd_reg(8'h10, 8'h06);
		ld(16'h0310, 8'hff);
		ld(16'h037f, 8'hff);
		rd_reg(8'h04, 8'ha0);
		wr_reg(8'h00, 8'h00);
		wr_reg(8'h04, 8'ha1);
		stall_is(1'b0);
		rd_reg(8'h04, 8'ha1);
		wr_reg(8'h04, 8'h61);
		rd_reg(8'h10, 8'h00);
		wr_reg(8'h00, 8'ha5);
		wr_reg(8'h04, 8'h51);
		i_cpu.store(16'h0320, 8'h5a);
		wr_reg(8'h04, 8'h61);
		rd_reg(8'h10, 8'h05);
		rd_reg(8'h04, 8'h60);
		wr_reg(8'h04, 8'h51);
		i_cpu.store(16'h0321, 8'h00);
		ld(16'h0321, 8'hff);
		wr_reg(8'h04, 8'ha1);
		stall_is(1'b0);
		ld(16'h0320, 8'h5a);
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_reg(8'h10, 8'h01);
		rd_reg(8'h00, 8'h00);
		tool_erase();
		rd_reg(8'h10, 8'h00);
		ld(16'h0320, 8'hff);
		stop_test();
	end
endmodule
`default_nettype wire
